/* File: bbt_consts.svh */
`ifndef BBT_CONSTS_SVH
`define BBT_CONSTS_SVH

// external bus cycle length in clock periods
`define BBT_BUS_CYC 4'h4
// move timing bases
`define BBT_MOVW_REG_MEM_CLK 8'h10
`define BBT_MOVW_REG_MEM_RD 4'h2
`define BBT_MOVW_REG_MEM_WR 4'h2
`define BBT_MOVL_REG_REG_CLK 8'h08
`define BBT_MOVL_REG_REG_RD 4'h2
`define BBT_MOVL_REG_MEM_CLK 8'h18
`define BBT_MOVL_REG_MEM_RD 4'h2
`define BBT_MOVL_REG_MEM_WR 4'h4
// two-operand arithmetic bases
`define BBT_ARITH_BW_CLK 8'h08
`define BBT_ARITH_L_CLK 8'h0a
`define BBT_ARITH_L_REGIMM_CLK 8'h0c
// byte and word operations into an address register, and the base read count used by every operation except the moves
`define BBT_ADDR_ARITH_W_CLK 8'h0c
`define BBT_ARITH_RD 4'h2
// exclusive-or into register
`define BBT_XOR_BW_CLK 8'h08
`define BBT_XOR_L_CLK 8'h0c
// multiply and divide
`define BBT_MUL_BASE_CLK 8'h2a
`define BBT_MUL_MAX_CLK 8'h4a
`define BBT_SDIV_CLK 8'ha2
`define BBT_UDIV_CLK 8'h90

`endif

/* File: bbt_pkg.sv */
package bbt_pkg;
	typedef enum logic [3:0] {
		BBT_OP_MOVW_REG_MEM,
		BBT_OP_MOVL_REG_REG,
		BBT_OP_MOVL_REG_MEM,
		BBT_OP_ARITH,
		BBT_OP_ADDR_ARITH,
		BBT_OP_XOR_REG,
		BBT_OP_SMUL,
		BBT_OP_UMUL,
		BBT_OP_SDIV,
		BBT_OP_UDIV
	} bbt_op_t;
	typedef enum logic [1:0] {
		BBT_SZ_BYTE,
		BBT_SZ_WORD,
		BBT_SZ_LONG
	} bbt_size_t;
	typedef enum logic [1:0] {
		BBT_BUS_IDLE,
		BBT_BUS_READ,
		BBT_BUS_WRITE
	} bbt_bus_t;
endpackage

/* File: bbt_timer.sv */
`timescale 1ns/1ps
`include "bbt_consts.svh"
// ****************************************************************
// instruction cycle timer for an 8-bit external data bus
// ****************************************************************
// Functional notes
// - every bus read or write lasts four clocks
// - result is total clocks, reads, writes
// - word register to indirect memory: 16(2/2)
// - long reg-reg 8(2/0), reg-memory 24(2/4)
// - index register size never changes timing
// - counts cover operate, store, next fetch
// - operand locator time added where marked
// - long base 10 becomes 12 for reg/imm
// - xor: data register only, 8/12 clocks
// - divide 162/144, multiply 74 maximum
// - divide spread under ten percent
// - multiply takes 42 plus 2n clocks
// - signed multiply: transitions in 17-bit value
// - unsigned multiply: n counts one bits
// - immediate counts include operand word fetches
module bbt_timer (
	input wire logic ref_clk_i,
	input wire logic rst_i,
	input wire logic start_i,
	input wire bbt_pkg::bbt_op_t op_i,
	input wire bbt_pkg::bbt_size_t size_i,
	input wire logic src_reg_or_imm_i,
	input wire logic src_data_reg_i,
	input wire logic index_long_i,
	input wire logic [15:0] mul_src_i,
	input wire logic [7:0] loc_clk_i,
	input wire logic [3:0] loc_rd_i,
	input wire logic [3:0] loc_wr_i,
	output logic busy_o,
	output logic done_o,
	output logic illegal_o,
	output bbt_pkg::bbt_bus_t bus_phase_o,
	output logic [7:0] total_clk_o,
	output logic [3:0] rd_cnt_o,
	output logic [3:0] wr_cnt_o
);
	import bbt_pkg::*;

	typedef enum logic [1:0] {
		BBT_ST_IDLE,
		BBT_ST_RUN,
		BBT_ST_DONE
	} bbt_state_t;

	bbt_state_t state_r;
	logic [7:0] base_clk;
	logic [3:0] base_rd;
	logic [3:0] base_wr;
	logic bad;
	logic [4:0] mul_n;
	logic [16:0] mul_ext;
	logic [7:0] tot_nxt;
	logic [3:0] rd_nxt;
	logic [3:0] wr_nxt;
	logic [7:0] clk_left_r;
	logic [3:0] rd_left_r;
	logic [3:0] wr_left_r;
	logic [1:0] phase_cnt_r;
	logic unused_idx;

	// ****************************************************************
	// base timing lookup
	// ****************************************************************
	// index width ignored
	assign unused_idx = index_long_i;

	// multiply bit-event count n
	always_comb begin
		mul_n = 5'h00;
		mul_ext = {1'b0, mul_src_i};
		for (int i = 0; i < 16; i++) begin
			if (op_i == BBT_OP_SMUL) begin
				mul_n = mul_n + 5'((mul_ext[i] ^ mul_ext[i + 1]) ? 1 : 0);
			end else begin
				mul_n = mul_n + 5'(mul_src_i[i] ? 1 : 0);
			end
		end
	end

	// bases include operate, store and next fetch
	always_comb begin
		base_clk = 8'h00;
		base_rd = `BBT_ARITH_RD;
		base_wr = 4'h0;
		bad = 1'b0;
		unique case (op_i)
			BBT_OP_MOVW_REG_MEM: begin
				base_clk = `BBT_MOVW_REG_MEM_CLK;
				base_rd = `BBT_MOVW_REG_MEM_RD;
				base_wr = `BBT_MOVW_REG_MEM_WR;
			end
			BBT_OP_MOVL_REG_REG: begin
				base_clk = `BBT_MOVL_REG_REG_CLK;
				base_rd = `BBT_MOVL_REG_REG_RD;
			end
			BBT_OP_MOVL_REG_MEM: begin
				base_clk = `BBT_MOVL_REG_MEM_CLK;
				base_rd = `BBT_MOVL_REG_MEM_RD;
				base_wr = `BBT_MOVL_REG_MEM_WR;
			end
			BBT_OP_ARITH, BBT_OP_ADDR_ARITH: begin
				if (size_i == BBT_SZ_LONG) begin
					base_clk = src_reg_or_imm_i ? `BBT_ARITH_L_REGIMM_CLK : `BBT_ARITH_L_CLK;
				end else if (op_i == BBT_OP_ADDR_ARITH) begin
					// address register destination is slower for short sizes
					base_clk = `BBT_ADDR_ARITH_W_CLK;
				end else begin
					base_clk = `BBT_ARITH_BW_CLK;
				end
			end
			BBT_OP_XOR_REG: begin
				bad = !src_data_reg_i;
				base_clk = (size_i == BBT_SZ_LONG) ? `BBT_XOR_L_CLK : `BBT_XOR_BW_CLK;
			end
			BBT_OP_SMUL, BBT_OP_UMUL: begin
				// 42 + 2n, bounded by 74
				base_clk = `BBT_MUL_BASE_CLK + {2'h0, mul_n, 1'b0};
			end
			BBT_OP_SDIV: begin
				// fixed worst case keeps spread zero
				base_clk = `BBT_SDIV_CLK;
			end
			BBT_OP_UDIV: begin
				base_clk = `BBT_UDIV_CLK;
			end
			default: begin
				bad = 1'b1;
			end
		endcase
	end

	// operand locator and immediate words added
	always_comb begin
		tot_nxt = base_clk + loc_clk_i;
		rd_nxt = base_rd + loc_rd_i;
		wr_nxt = base_wr + loc_wr_i;
	end

	// ****************************************************************
	// sequencer
	// ****************************************************************
	// control state; new starts are ignored while busy
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			state_r <= BBT_ST_IDLE;
		end else begin
			unique case (state_r)
				BBT_ST_IDLE: if (start_i) state_r <= BBT_ST_RUN;
				BBT_ST_RUN: if (clk_left_r == 8'h01) state_r <= BBT_ST_DONE;
				BBT_ST_DONE: state_r <= BBT_ST_IDLE;
			endcase
		end
	end

	// latch the result triple at start
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			total_clk_o <= 8'h00;
			rd_cnt_o <= 4'h0;
			wr_cnt_o <= 4'h0;
			illegal_o <= 1'b0;
		end else if (state_r == BBT_ST_IDLE && start_i) begin
			total_clk_o <= tot_nxt;
			rd_cnt_o <= rd_nxt;
			wr_cnt_o <= wr_nxt;
			illegal_o <= bad;
		end
	end

	// clock countdown and bus cycle bookkeeping
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			clk_left_r <= 8'h00;
			rd_left_r <= 4'h0;
			wr_left_r <= 4'h0;
			phase_cnt_r <= 2'h0;
		end else if (state_r == BBT_ST_IDLE) begin
			// a zero total would wrap and run 256 clocks, so run at least one clock
			clk_left_r <= (tot_nxt == 8'h00) ? 8'h01 : tot_nxt;
			rd_left_r <= rd_nxt;
			wr_left_r <= wr_nxt;
			phase_cnt_r <= 2'h0;
		end else if (state_r == BBT_ST_RUN) begin
			clk_left_r <= clk_left_r - 8'h01;
			if (rd_left_r != 4'h0 || wr_left_r != 4'h0) begin
				phase_cnt_r <= phase_cnt_r + 2'h1;
				if (phase_cnt_r == 2'(`BBT_BUS_CYC - 4'h1)) begin
					if (rd_left_r != 4'h0) rd_left_r <= rd_left_r - 4'h1;
					else wr_left_r <= wr_left_r - 4'h1;
				end
			end
		end
	end

	// registered status and bus phase outputs
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			busy_o <= 1'b0;
			done_o <= 1'b0;
			bus_phase_o <= BBT_BUS_IDLE;
		end else begin
			busy_o <= (state_r == BBT_ST_IDLE) ? start_i : (state_r == BBT_ST_RUN && clk_left_r != 8'h01);
			done_o <= (state_r == BBT_ST_RUN && clk_left_r == 8'h01);
			// bus idle once all reads and writes are spent
			if (state_r == BBT_ST_IDLE && start_i) begin
				bus_phase_o <= (rd_nxt != 4'h0) ? BBT_BUS_READ :
					(wr_nxt != 4'h0) ? BBT_BUS_WRITE : BBT_BUS_IDLE;
			end else if (state_r == BBT_ST_RUN && clk_left_r != 8'h01) begin
				if (phase_cnt_r != 2'h3) bus_phase_o <= bus_phase_o;
				else if (rd_left_r > 4'h1) bus_phase_o <= BBT_BUS_READ;
				else if (rd_left_r == 4'h1 && wr_left_r != 4'h0) bus_phase_o <= BBT_BUS_WRITE;
				else if (rd_left_r == 4'h0 && wr_left_r > 4'h1) bus_phase_o <= BBT_BUS_WRITE;
				else bus_phase_o <= BBT_BUS_IDLE;
			end else begin
				bus_phase_o <= BBT_BUS_IDLE;
			end
		end
	end
endmodule

/* File: bbt_timer_props.sv */
`timescale 1ns/1ps
module bbt_timer_props (
	input wire logic ref_clk_i,
	input wire logic rst_i,
	input wire logic start_i,
	input wire bbt_pkg::bbt_op_t op_i,
	input wire bbt_pkg::bbt_size_t size_i,
	input wire logic src_reg_or_imm_i,
	input wire logic src_data_reg_i,
	input wire logic index_long_i,
	input wire logic [15:0] mul_src_i,
	input wire logic [7:0] loc_clk_i,
	input wire logic [3:0] loc_rd_i,
	input wire logic [3:0] loc_wr_i,
	input wire logic busy_o,
	input wire logic done_o,
	input wire logic illegal_o,
	input wire bbt_pkg::bbt_bus_t bus_phase_o,
	input wire logic [7:0] total_clk_o,
	input wire logic [3:0] rd_cnt_o,
	input wire logic [3:0] wr_cnt_o
);
	import bbt_pkg::*;
	logic acc;
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (rst_i);
	// a start is only taken from the idle state
	assign acc = start_i && !busy_o && !done_o;
	a_idle_when_free: assert property (!busy_o |-> bus_phase_o == BBT_BUS_IDLE)
		else $error("bus active while not busy");
	a_reads_whole: assert property ((bus_phase_o == BBT_BUS_READ &&
		$past(bus_phase_o) != BBT_BUS_READ) |-> (bus_phase_o == BBT_BUS_READ)[*4])
		else $error("read cycle shorter than four clocks");
	a_writes_whole: assert property ((bus_phase_o == BBT_BUS_WRITE &&
		$past(bus_phase_o) != BBT_BUS_WRITE) |-> (bus_phase_o == BBT_BUS_WRITE)[*4])
		else $error("write cycle shorter than four clocks");
	a_start_reads: assert property (acc |=> busy_o && bus_phase_o == BBT_BUS_READ)
		else $error("start did not begin with a read");
	a_done_ends: assert property ($fell(busy_o) |-> done_o)
		else $error("busy ended without done");
	a_done_pulse: assert property (done_o |=> !done_o && !busy_o)
		else $error("done longer than one cycle");
	a_result_holds: assert property (busy_o && $past(busy_o) |->
		$stable(total_clk_o) && $stable(rd_cnt_o) && $stable(wr_cnt_o))
		else $error("result changed while running");
	a_xor_refused: assert property (acc && op_i == BBT_OP_XOR_REG && !src_data_reg_i
		|=> illegal_o) else $error("xor source not flagged");
	a_div_signed: assert property (acc && op_i == BBT_OP_SDIV |=>
		total_clk_o == 8'ha2 + $past(loc_clk_i)) else $error("signed divide total wrong");
	c_done: cover property (done_o);
	c_illegal: cover property (done_o && illegal_o);
	c_smul: cover property (acc && op_i == BBT_OP_SMUL);
endmodule
bind bbt_timer bbt_timer_props u_props (.*);

/* File: bbt_mem_model.sv */
`timescale 1ns/1ps
// ****************************************************************
// external memory: zero wait states, counts bus clocks per phase
// ****************************************************************
module bbt_mem_model (
	input wire logic ref_clk_i,
	input wire logic rst_i,
	input wire logic clr_i,
	input wire bbt_pkg::bbt_bus_t bus_phase_i,
	output int rd_clk_o,
	output int wr_clk_o
);
	import bbt_pkg::*;
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			rd_clk_o <= 0;
			wr_clk_o <= 0;
		end else if (clr_i) begin
			rd_clk_o <= 0;
			wr_clk_o <= 0;
		end else begin
			rd_clk_o <= rd_clk_o + (bus_phase_i == BBT_BUS_READ);
			wr_clk_o <= wr_clk_o + (bus_phase_i == BBT_BUS_WRITE);
		end
	end
endmodule

/* File: byte_bus_instruction_cycle_timing_tb_top.sv */
`timescale 1ns/1ps
module byte_bus_instruction_cycle_timing_tb_top;
	import bbt_pkg::*;
	logic clk = 0, rst = 1, start = 0, ri = 0, dr = 0, idx = 0, clr = 0;
	bbt_op_t op = BBT_OP_ARITH;
	bbt_size_t sz = BBT_SZ_BYTE;
	logic [15:0] mul = 0;
	logic [7:0] lc = 0, tot;
	logic [3:0] lr = 0, lw = 0, rd, wr;
	logic busy, done, ill;
	bbt_bus_t ph;
	int rdc, wrc, num_errors = 0, num_checks = 0;
	bbt_timer u_dut (.ref_clk_i(clk), .rst_i(rst), .start_i(start), .op_i(op), .size_i(sz),
		.src_reg_or_imm_i(ri), .src_data_reg_i(dr), .index_long_i(idx), .mul_src_i(mul),
		.loc_clk_i(lc), .loc_rd_i(lr), .loc_wr_i(lw), .busy_o(busy), .done_o(done),
		.illegal_o(ill), .bus_phase_o(ph), .total_clk_o(tot), .rd_cnt_o(rd), .wr_cnt_o(wr));
	bbt_mem_model u_mem (.ref_clk_i(clk), .rst_i(rst), .clr_i(clr), .bus_phase_i(ph),
		.rd_clk_o(rdc), .wr_clk_o(wrc));
	initial begin
		forever #4 clk = ~clk;
	end
	task summarize;
		$display("errors %0d checks %0d", num_errors, num_checks);
		if (num_errors == 0 && num_checks > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	task chk_cnt(input logic [7:0] got, input logic [7:0] exp);
		num_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("mismatch at %0t: count %0d expected %0d", $time, got, exp);
		end
	endtask
	task chk_flag(input logic got, input logic exp);
		num_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("mismatch at %0t: illegal flag %b", $time, got);
		end
	endtask
	// reference model in integers, then one run with bounded wait
	task run(input bbt_op_t o, input bbt_size_t s, input bit r_i, input bit d_r,
		input logic [15:0] m, input bit hold);
		int t, r, w, n, a, b, c;
		logic [16:0] x;
		a = (o <= BBT_OP_MOVL_REG_MEM) ? 0 : $urandom % 3;
		b = (o <= BBT_OP_MOVL_REG_MEM) ? 0 : $urandom % 3;
		c = a == 0 && b == 0 ? 0 : 4 * (a + b) + 2 * ($urandom % 4);
		x = {1'b0, m};
		n = 0;
		r = 2 + a;
		w = b;
		for (int i = 0; i < 16; i++) n += (o == BBT_OP_SMUL) ? (x[i + 1] ^ x[i]) : m[i];
		case (o)
			BBT_OP_MOVW_REG_MEM: begin t = 16; w += 2; end
			BBT_OP_MOVL_REG_REG: t = 8;
			BBT_OP_MOVL_REG_MEM: begin t = 24; w += 4; end
			BBT_OP_ARITH: t = s != BBT_SZ_LONG ? 8 : r_i ? 12 : 10;
			BBT_OP_ADDR_ARITH: t = s != BBT_SZ_LONG ? 12 : r_i ? 12 : 10;
			BBT_OP_XOR_REG: t = s == BBT_SZ_LONG ? 12 : 8;
			BBT_OP_SDIV: t = 162;
			BBT_OP_UDIV: t = 144;
			default: t = 42 + 2 * n;
		endcase
		t += c;
		@(posedge clk);
		{start, clr, op, sz, ri, dr, mul, idx} <= {2'b11, o, s, r_i, d_r, m, 1'($urandom)};
		{lc, lr, lw} <= {8'(c), 4'(a), 4'(b)};
		@(posedge clk);
		{start, clr} <= {hold, 1'b0};
		// a refused start carries a signed divide request
		if (hold) op <= BBT_OP_SDIV;
		n = 0;
		while (done !== 1'b1 && n < 300) begin
			@(posedge clk);
			n++;
		end
		start <= 0;
		if (n >= 300) begin
			num_errors++;
			summarize;
		end
		chk_cnt(tot, 8'(t));
		chk_cnt({4'h0, rd}, 8'(r));
		chk_cnt({4'h0, wr}, 8'(w));
		chk_cnt(8'(n), 8'(t + 1));
		chk_cnt(8'(rdc), 8'(4 * r));
		chk_cnt(8'(wrc), 8'(4 * w));
		chk_flag(ill, o == BBT_OP_XOR_REG && !d_r);
	endtask
	initial begin
		bbt_op_t o;
		bbt_size_t s;
		void'($urandom(28));
		repeat (10) @(posedge clk);
		rst <= 0;
		run(BBT_OP_MOVW_REG_MEM, BBT_SZ_WORD, 0, 1, 0, 0);
		run(BBT_OP_MOVL_REG_REG, BBT_SZ_LONG, 0, 1, 0, 0);
		run(BBT_OP_MOVL_REG_MEM, BBT_SZ_LONG, 0, 1, 0, 1);
		run(BBT_OP_ARITH, BBT_SZ_LONG, 1, 1, 0, 0);
		run(BBT_OP_ADDR_ARITH, BBT_SZ_LONG, 0, 1, 0, 0);
		run(BBT_OP_XOR_REG, BBT_SZ_LONG, 0, 0, 0, 0);
		run(BBT_OP_SDIV, BBT_SZ_WORD, 0, 1, 0, 1);
		run(BBT_OP_UDIV, BBT_SZ_WORD, 0, 1, 0, 0);
		run(BBT_OP_SMUL, BBT_SZ_WORD, 0, 1, 16'h5555, 0);
		run(BBT_OP_UMUL, BBT_SZ_WORD, 0, 1, 16'hffff, 0);
		run(BBT_OP_UMUL, BBT_SZ_WORD, 0, 1, 16'h0000, 0);
		repeat (40) begin
			o = bbt_op_t'($urandom % 10);
			s = bbt_size_t'($urandom % 3);
			if (o == BBT_OP_ADDR_ARITH && s == BBT_SZ_BYTE) s = BBT_SZ_WORD;
			run(o, s, 1'($urandom), 1'($urandom), 16'($urandom), $urandom % 4 == 0);
		end
		summarize;
	end
endmodule
